// ### design/acrb_core.sv
`timescale 1ns/10ps
`default_nettype none
module acrb_core
  import acrb_pkg::*;
#(
  parameter int TIMER_W = 8
) (
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  // Instruction issue
  input  wire logic                   op_valid_i,
  input  wire logic [7:0]             opcode_i,
  output logic                        op_ready_o,
  // Interrupt entry and service exit
  input  wire logic                   irq_taken_i,
  input  wire logic                   isr_exit_restore_i,
  // Event pin, asynchronous
  input  wire logic                   event_count_input_i,
  // Timer load from the core
  input  wire logic                   timer_load_i,
  input  wire logic [TIMER_W-1:0]     timer_load_data_i,
  // Data memory port, read data one cycle after mem_rd_o
  output logic [DMEM_ADDR_W-1:0]      mem_addr_o,
  output logic                        mem_rd_o,
  output logic                        mem_we_o,
  output logic [7:0]                  mem_wdata_o,
  input  wire logic [7:0]             mem_rdata_i,
  // Architectural state
  output logic [7:0]                  acc_o,
  output logic                        carry_o,
  output logic                        program_bank_flag_o,
  output logic                        register_bank_flag_o,
  // Timer and counter
  output logic [TIMER_W-1:0]          timer_value_o,
  output logic                        timer_overflow_o,
  output logic                        timer_running_o,
  output logic                        counter_running_o
);

  typedef struct packed {
    acrb_state_t              st;
    logic [7:0]               acc;
    logic                     carry;
    logic                     pbf;
    logic                     rbf;
    logic                     rbf_saved;
    logic                     ptr_phase;
    logic                     nib;
    logic [DMEM_ADDR_W-1:0]   addr;
    logic                     rd;
    logic                     we;
    logic [7:0]               wdata;
    logic [2:0]               ev_sync;
  } acrb_cstate_t;

  acrb_cstate_t q, d;
  logic         accept;
  logic         halt_cmd;
  logic         start_tmr_cmd;
  logic         start_cnt_cmd;
  logic         ev_fall;

  function automatic logic [DMEM_ADDR_W-1:0] reg_addr(input logic bank,
                                                       input logic [2:0] r);
    reg_addr = (bank ? REG_BANK1_BASE : REG_BANK0_BASE) + {3'b000, r};
  endfunction

  assign accept  = op_valid_i && (q.st == ST_IDLE);
  // Falling edge from the two stages behind the first synchroniser flop
  assign ev_fall = q.ev_sync[2] && !q.ev_sync[1];

  always_comb begin
    d             = q;
    d.rd          = 1'b0;
    d.we          = 1'b0;
    d.ev_sync     = {q.ev_sync[1:0], event_count_input_i};
    halt_cmd      = 1'b0;
    start_tmr_cmd = 1'b0;
    start_cnt_cmd = 1'b0;
    if (irq_taken_i) begin
      d.rbf_saved = q.rbf;
    end
    case (q.st)
      ST_IDLE: begin
        if (op_valid_i) begin
          case (opcode_i)
            OP_ROTATE_LEFT_PLAIN: begin
              d.acc = {q.acc[6:0], q.acc[7]};
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
              d.acc   = {q.acc[6:0], q.carry};
              d.carry = q.acc[7];
            end
            OP_ROTATE_RIGHT_PLAIN: begin
              d.acc = {q.acc[0], q.acc[7:1]};
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
              d.acc   = {q.carry, q.acc[7:1]};
              d.carry = q.acc[0];
            end
            OP_NIBBLE_SWAP: begin
              d.acc = {q.acc[3:0], q.acc[7:4]};
            end
            OP_CHOOSE_PROGRAM_BANK_LOW: begin
              d.pbf = 1'b0;
            end
            OP_CHOOSE_PROGRAM_BANK_HIGH: begin
              d.pbf = 1'b1;
            end
            OP_CHOOSE_REGISTER_BANK_LOW: begin
              d.rbf = 1'b0;
            end
            OP_CHOOSE_REGISTER_BANK_HIGH: begin
              d.rbf = 1'b1;
            end
            OP_HALT_TIMER_COUNTER: begin
              halt_cmd = 1'b1;
            end
            OP_BEGIN_EVENT_COUNTING: begin
              start_cnt_cmd = 1'b1;
            end
            OP_BEGIN_INTERVAL_TIMING: begin
              start_tmr_cmd = 1'b1;
            end
            default: begin
              // Exchange opcodes start a memory access; any other opcode here is accepted and leaves all state alone
              if (opcode_i[7:3] == OP_ACC_REGISTER_EXCHANGE[7:3]) begin
                d.addr      = reg_addr(q.rbf, opcode_i[2:0]);
                d.rd        = 1'b1;
                d.ptr_phase = 1'b0;
                d.nib       = 1'b0;
                d.st        = ST_WAIT;
              end else if (opcode_i[7:1] == OP_ACC_INDIRECT_EXCHANGE[7:1] ||
                           opcode_i[7:1] == OP_ACC_LOW_NIBBLE_EXCHANGE[7:1]) begin
                // First fetch the pointer register of the current bank
                d.addr      = reg_addr(q.rbf, {2'b00, opcode_i[0]});
                d.rd        = 1'b1;
                d.ptr_phase = 1'b1;
                d.nib       = opcode_i[4];
                d.st        = ST_WAIT;
              end
            end
          endcase
        end
      end
      ST_WAIT: begin
        d.st = q.ptr_phase ? ST_PTR : ST_XFER;
      end
      ST_PTR: begin
        // Only pointer bits 0-5 address memory; the pointer is never written
        d.addr      = mem_rdata_i[DMEM_ADDR_W-1:0];
        d.rd        = 1'b1;
        d.ptr_phase = 1'b0;
        d.st        = ST_WAIT;
      end
      ST_XFER: begin
        d.we = 1'b1;
        if (q.nib) begin
          d.wdata = {mem_rdata_i[7:4], q.acc[3:0]};
          d.acc   = {q.acc[7:4], mem_rdata_i[3:0]};
        end else begin
          d.wdata = q.acc;
          d.acc   = mem_rdata_i;
        end
        d.st = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase
    if (isr_exit_restore_i) begin
      d.rbf = q.rbf_saved;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  acrb_timer #(
    .TIMER_W (TIMER_W)
  ) u_timer (
    .sys_clk_i         (sys_clk_i),
    .resetn_i          (resetn_i),
    .halt_i            (halt_cmd),
    .start_timer_i     (start_tmr_cmd),
    .start_counter_i   (start_cnt_cmd),
    .load_i            (timer_load_i),
    .load_data_i       (timer_load_data_i),
    .count_edge_i      (ev_fall),
    .value_o           (timer_value_o),
    .overflow_o        (timer_overflow_o),
    .timer_running_o   (timer_running_o),
    .counter_running_o (counter_running_o)
  );

  assign op_ready_o           = (q.st == ST_IDLE);
  assign mem_addr_o           = q.addr;
  assign mem_rd_o             = q.rd;
  assign mem_we_o             = q.we;
  assign mem_wdata_o          = q.wdata;
  assign acc_o                = q.acc;
  assign carry_o              = q.carry;
  assign program_bank_flag_o  = q.pbf;
  assign register_bank_flag_o = q.rbf;

  // Previous-cycle copies used only by the checks below
  logic [7:0] h_acc_r;
  logic       h_carry_r;
  logic [7:0] h_op_r;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      h_acc_r   <= ACC_RESET;
      h_carry_r <= 1'b0;
      h_op_r    <= 8'h00;
    end else begin
      h_acc_r   <= acc_o;
      h_carry_r <= carry_o;
      h_op_r    <= opcode_i;
    end
  end

  a_rotate_left_plain: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i == OP_ROTATE_LEFT_PLAIN
    |=> acc_o == {h_acc_r[6:0], h_acc_r[7]} && carry_o == h_carry_r)
    else $error("plain left rotate wrong");

  a_rotate_left_carry: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i == OP_ROTATE_LEFT_THROUGH_CARRY
    |=> acc_o == {h_acc_r[6:0], h_carry_r} && carry_o == h_acc_r[7])
    else $error("left rotate through carry wrong");

  a_rotate_right_plain: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i == OP_ROTATE_RIGHT_PLAIN
    |=> acc_o == {h_acc_r[0], h_acc_r[7:1]} && carry_o == h_carry_r)
    else $error("plain right rotate wrong");

  a_rotate_right_carry: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i == OP_ROTATE_RIGHT_THROUGH_CARRY
    |=> acc_o == {h_carry_r, h_acc_r[7:1]} && carry_o == h_acc_r[0])
    else $error("right rotate through carry wrong");

  a_nibble_swap_op: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i == OP_NIBBLE_SWAP
    |=> acc_o == {h_acc_r[3:0], h_acc_r[7:4]} && carry_o == h_carry_r)
    else $error("nibble swap wrong");

  a_program_bank_sel: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && (opcode_i == OP_CHOOSE_PROGRAM_BANK_LOW ||
               opcode_i == OP_CHOOSE_PROGRAM_BANK_HIGH)
    |=> program_bank_flag_o == h_op_r[4] ##1 program_bank_flag_o == h_op_r[4]
        || op_ready_o)
    else $error("program bank flag wrong");

  a_register_bank_sel: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && !isr_exit_restore_i && (opcode_i == OP_CHOOSE_REGISTER_BANK_LOW ||
                                      opcode_i == OP_CHOOSE_REGISTER_BANK_HIGH)
    |=> register_bank_flag_o == h_op_r[4] && carry_o == h_carry_r)
    else $error("register bank flag wrong");

  a_bank_restore_exit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (irq_taken_i && !isr_exit_restore_i) ##1 (isr_exit_restore_i && !irq_taken_i)
    |=> register_bank_flag_o == $past(register_bank_flag_o, 2))
    else $error("bank not restored on service exit");

  a_reg_exchange_seq: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i[7:3] == OP_ACC_REGISTER_EXCHANGE[7:3]
    |=> (mem_rd_o && mem_addr_o[2:0] == h_op_r[2:0] &&
         mem_addr_o[4:3] == {2{register_bank_flag_o}})
        ##2 (mem_we_o && mem_wdata_o == h_acc_r && op_ready_o))
    else $error("register exchange sequence wrong");

  a_ind_exchange_seq: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i[7:1] == OP_ACC_INDIRECT_EXCHANGE[7:1]
    |=> mem_rd_o ##1 !mem_rd_o ##1 mem_rd_o ##2 (mem_we_o && mem_wdata_o == h_acc_r))
    else $error("indirect exchange sequence wrong");

  a_nibble_exchange: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    accept && opcode_i[7:1] == OP_ACC_LOW_NIBBLE_EXCHANGE[7:1]
    |-> ##5 (mem_we_o && acc_o[7:4] == h_acc_r[7:4] &&
             mem_wdata_o[3:0] == h_acc_r[3:0] && carry_o == h_carry_r))
    else $error("low nibble exchange wrong");

endmodule
`default_nettype wire

// ### inc/acrb_pkg.sv
`default_nettype none
package acrb_pkg;

  // Opcodes handled by this block
  localparam logic [7:0] OP_ROTATE_LEFT_PLAIN          = 8'he7;
  localparam logic [7:0] OP_ROTATE_LEFT_THROUGH_CARRY  = 8'hf7;
  localparam logic [7:0] OP_ROTATE_RIGHT_PLAIN         = 8'h77;
  localparam logic [7:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 8'h67;
  localparam logic [7:0] OP_CHOOSE_PROGRAM_BANK_LOW    = 8'he5;
  localparam logic [7:0] OP_CHOOSE_PROGRAM_BANK_HIGH   = 8'hf5;
  localparam logic [7:0] OP_CHOOSE_REGISTER_BANK_LOW   = 8'hc5;
  localparam logic [7:0] OP_CHOOSE_REGISTER_BANK_HIGH  = 8'hd5;
  localparam logic [7:0] OP_HALT_TIMER_COUNTER         = 8'h65;
  localparam logic [7:0] OP_BEGIN_EVENT_COUNTING       = 8'h45;
  localparam logic [7:0] OP_BEGIN_INTERVAL_TIMING      = 8'h55;
  localparam logic [7:0] OP_NIBBLE_SWAP                = 8'h47;
  localparam logic [7:0] OP_ACC_REGISTER_EXCHANGE      = 8'h28;
  localparam logic [7:0] OP_ACC_INDIRECT_EXCHANGE      = 8'h20;
  localparam logic [7:0] OP_ACC_LOW_NIBBLE_EXCHANGE    = 8'h30;

  // Data memory layout
  localparam int         DMEM_ADDR_W     = 6;
  localparam logic [5:0] REG_BANK0_BASE  = 6'h00;
  localparam logic [5:0] REG_BANK1_BASE  = 6'h18;

  // Timer prescaler: one timer tick per 32 instruction cycles
  localparam int         PRESCALE_W      = 5;
  localparam logic [4:0] PRESCALE_LAST   = 5'h1f;
  localparam logic [4:0] PRESCALE_RESET  = 5'h00;

  // Reset values
  localparam logic [7:0] ACC_RESET       = 8'h00;
  localparam logic [7:0] TIMER_RESET     = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_PTR  = 2'b10,
    ST_XFER = 2'b11
  } acrb_state_t;

  typedef enum logic [1:0] {
    TM_STOP    = 2'b00,
    TM_TIMER   = 2'b01,
    TM_COUNTER = 2'b10
  } acrb_tmode_t;

endpackage
`default_nettype wire

// ### design/acrb_timer.sv
`timescale 1ns/10ps
`default_nettype none
module acrb_timer
  import acrb_pkg::*;
#(
  parameter int TIMER_W = 8
) (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               resetn_i,
  // Commands from the decoder, and the timer load from the core
  input  wire logic               halt_i,
  input  wire logic               start_timer_i,
  input  wire logic               start_counter_i,
  input  wire logic               load_i,
  input  wire logic [TIMER_W-1:0] load_data_i,
  // Synchronised falling edge of the event input
  input  wire logic               count_edge_i,
  // Status
  output logic [TIMER_W-1:0]      value_o,
  output logic                    overflow_o,
  output logic                    timer_running_o,
  output logic                    counter_running_o
);

  typedef struct packed {
    acrb_tmode_t               mode;
    logic [PRESCALE_W-1:0]     pre;
    logic [TIMER_W-1:0]        value;
    logic                      ovf;
  } acrb_tstate_t;

  acrb_tstate_t q, d;
  logic         tick;

  always_comb begin
    d     = q;
    d.ovf = 1'b0;
    tick  = 1'b0;
    case (q.mode)
      TM_TIMER: begin
        d.pre = q.pre + 5'h01;
        if (q.pre == PRESCALE_LAST) begin
          d.pre = PRESCALE_RESET;
          tick  = 1'b1;
        end
      end
      TM_COUNTER: tick = count_edge_i;
      TM_STOP:    tick = 1'b0;
      default:    d.mode = TM_STOP;
    endcase
    if (tick) begin
      d.value = q.value + {{(TIMER_W-1){1'b0}}, 1'b1};
      d.ovf   = &q.value;
    end
    if (load_i) begin
      d.value = load_data_i;
    end
    if (halt_i) begin
      d.mode = TM_STOP;
    end else if (start_counter_i) begin
      d.mode = TM_COUNTER;
    end else if (start_timer_i) begin
      // Prescaler restarts, the count itself carries on
      d.mode = TM_TIMER;
      d.pre  = PRESCALE_RESET;
      // A tick due in the same cycle is dropped so the count stays put
      if (!load_i) begin
        d.value = q.value;
        d.ovf   = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value_o           = q.value;
  assign overflow_o        = q.ovf;
  assign timer_running_o   = (q.mode == TM_TIMER);
  assign counter_running_o = (q.mode == TM_COUNTER);

  a_timer_tick_rate: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (q.mode == TM_TIMER && q.pre == PRESCALE_LAST && !load_i && !halt_i
     && !start_counter_i && !start_timer_i) |=> value_o == $past(value_o) + 8'h01)
    else $error("timer did not tick after 32 cycles");

  a_timer_start_keeps: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (start_timer_i && !halt_i && !start_counter_i && !load_i)
    |=> (q.pre == PRESCALE_RESET && $stable(value_o) && timer_running_o))
    else $error("timer start changed count or kept prescaler");

  a_halt_freezes: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (halt_i ##1 (!load_i && !start_timer_i && !start_counter_i))
    |=> $stable(value_o) && !timer_running_o && !counter_running_o)
    else $error("count moved after halt");

  a_event_counts: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (counter_running_o && count_edge_i && !load_i && !halt_i && !start_timer_i)
    |=> value_o == $past(value_o) + 8'h01)
    else $error("event edge not counted");

endmodule
`default_nettype wire

// ### testbench/acrb_core_test.sv
`timescale 1ns/10ps
`default_nettype none
module acrb_core_test
  import acrb_pkg::*;
;
  localparam int LIMIT = 3000;

  typedef struct {
    logic [7:0] acc;
    logic       c;
    logic       pb;
    logic       rb;
    logic [7:0] tv;
    logic       tr;
    logic       cr;
    logic       ov;
    logic [5:0] ma;
    logic [7:0] mv;
  } acrb_note_t;

  logic             sys_clk_i           = 1'b0;
  logic             resetn_i            = 1'b0;
  logic             op_valid_i          = 1'b0;
  logic [7:0]       opcode_i            = 8'h00;
  logic             irq_taken_i         = 1'b0;
  logic             isr_exit_restore_i  = 1'b0;
  logic             event_count_input_i = 1'b0;
  logic             timer_load_i        = 1'b0;
  logic [7:0]       timer_load_data_i   = 8'h00;
  logic [7:0]       mem_rdata_i         = 8'h00;
  logic             op_ready_o;
  logic [5:0]       mem_addr_o;
  logic             mem_rd_o;
  logic             mem_we_o;
  logic [7:0]       mem_wdata_o;
  logic [7:0]       acc_o;
  logic             carry_o;
  logic             program_bank_flag_o;
  logic             register_bank_flag_o;
  logic [7:0]       timer_value_o;
  logic             timer_overflow_o;
  logic             timer_running_o;
  logic             counter_running_o;
  logic [7:0]       mem [64];
  logic [7:0]       gold [64];
  logic [7:0]       s_acc;
  logic [7:0]       s_tv;
  logic             s_c;
  logic             s_pb;
  logic             s_rb;
  logic             s_tr;
  logic             s_cr;
  logic             s_ov;
  logic [7:0]       rot_ops [4];
  acrb_note_t       notes [$];
  acrb_note_t       m;
  event             note_ev;
  int               mismatches      = 0;
  int               samples_checked = 0;
  int               cycles          = 0;

  acrb_core #(.TIMER_W(8)) i_dut (
    .sys_clk_i            (sys_clk_i),
    .resetn_i             (resetn_i),
    .op_valid_i           (op_valid_i),
    .opcode_i             (opcode_i),
    .op_ready_o           (op_ready_o),
    .irq_taken_i          (irq_taken_i),
    .isr_exit_restore_i   (isr_exit_restore_i),
    .event_count_input_i  (event_count_input_i),
    .timer_load_i         (timer_load_i),
    .timer_load_data_i    (timer_load_data_i),
    .mem_addr_o           (mem_addr_o),
    .mem_rd_o             (mem_rd_o),
    .mem_we_o             (mem_we_o),
    .mem_wdata_o          (mem_wdata_o),
    .mem_rdata_i          (mem_rdata_i),
    .acc_o                (acc_o),
    .carry_o              (carry_o),
    .program_bank_flag_o  (program_bank_flag_o),
    .register_bank_flag_o (register_bank_flag_o),
    .timer_value_o        (timer_value_o),
    .timer_overflow_o     (timer_overflow_o),
    .timer_running_o      (timer_running_o),
    .counter_running_o    (counter_running_o)
  );

  always #20 sys_clk_i = ~sys_clk_i;

  // Data memory: read data one cycle after the strobe, scrambled otherwise
  always @(posedge sys_clk_i) begin
    if (mem_rd_o === 1'b1) mem_rdata_i <= mem[mem_addr_o];
    else mem_rdata_i <= ~mem_rdata_i;
    if (mem_we_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic note(input logic [5:0] ma);
    notes.push_back('{s_acc, s_c, s_pb, s_rb, s_tv, s_tr, s_cr, s_ov, ma, gold[ma]});
    -> note_ev;
  endtask

  always @(note_ev) begin
    while (notes.size() > 0) begin
      m = notes.pop_front();
      check("acc", acc_o, m.acc);
      check("carry", {7'h00, carry_o}, {7'h00, m.c});
      check("program_bank", {7'h00, program_bank_flag_o}, {7'h00, m.pb});
      check("register_bank", {7'h00, register_bank_flag_o}, {7'h00, m.rb});
      check("timer", timer_value_o, m.tv);
      check("running", {6'h00, timer_running_o, counter_running_o},
            {6'h00, m.tr, m.cr});
      check("overflow", {7'h00, timer_overflow_o}, {7'h00, m.ov});
      check("memory", mem[m.ma], m.mv);
      check("ready", {7'h00, op_ready_o}, 8'h01);
    end
  end

  // Offers one opcode, waits for completion and one more edge for the write
  task automatic do_op(input logic [7:0] op);
    @(posedge sys_clk_i);
    op_valid_i <= 1'b1;
    opcode_i   <= op;
    @(posedge sys_clk_i);
    op_valid_i <= 1'b0;
    #1;
    for (int k = 0; k < 10 && op_ready_o !== 1'b1; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic op1(input logic [7:0] op);
    do_op(op);
    case (op)
      OP_ROTATE_LEFT_PLAIN:          s_acc = {s_acc[6:0], s_acc[7]};
      OP_ROTATE_LEFT_THROUGH_CARRY:  {s_c, s_acc} = {s_acc, s_c};
      OP_ROTATE_RIGHT_PLAIN:         s_acc = {s_acc[0], s_acc[7:1]};
      OP_ROTATE_RIGHT_THROUGH_CARRY: {s_acc, s_c} = {s_c, s_acc};
      OP_NIBBLE_SWAP:                s_acc = {s_acc[3:0], s_acc[7:4]};
      OP_CHOOSE_PROGRAM_BANK_LOW:    s_pb = 1'b0;
      OP_CHOOSE_PROGRAM_BANK_HIGH:   s_pb = 1'b1;
      OP_CHOOSE_REGISTER_BANK_LOW:   s_rb = 1'b0;
      OP_CHOOSE_REGISTER_BANK_HIGH:  s_rb = 1'b1;
      OP_HALT_TIMER_COUNTER:         {s_tr, s_cr} = 2'b00;
      OP_BEGIN_EVENT_COUNTING:       {s_tr, s_cr} = 2'b01;
      OP_BEGIN_INTERVAL_TIMING:      {s_tr, s_cr} = 2'b10;
      default: ;
    endcase
    note(6'h00);
  endtask

  task automatic xch_reg(input logic [2:0] r);
    logic [5:0] a;
    logic [7:0] t;
    a = (s_rb ? REG_BANK1_BASE : REG_BANK0_BASE) + {3'h0, r};
    do_op(OP_ACC_REGISTER_EXCHANGE | {5'h00, r});
    t = s_acc;
    s_acc = gold[a];
    gold[a] = t;
    note(a);
  endtask

  task automatic xch_ind(input logic [7:0] op);
    logic [5:0] pa;
    logic [5:0] p;
    logic [7:0] t;
    pa = (s_rb ? REG_BANK1_BASE : REG_BANK0_BASE) + {5'h00, op[0]};
    p = gold[pa][5:0];
    do_op(op);
    t = s_acc;
    if (op[4]) begin
      s_acc = {t[7:4], gold[p][3:0]};
      gold[p] = {gold[p][7:4], t[3:0]};
    end else begin
      s_acc = gold[p];
      gold[p] = t;
    end
    note(p);
    #1;
    note(pa);
  endtask

  task automatic wait_note(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
    note(6'h00);
  endtask

  initial begin
    rot_ops = '{OP_ROTATE_LEFT_PLAIN, OP_ROTATE_LEFT_THROUGH_CARRY,
                OP_ROTATE_RIGHT_PLAIN, OP_ROTATE_RIGHT_THROUGH_CARRY};
    void'($urandom(14798));
    for (int i = 0; i < 64; i++) gold[i] = 8'($urandom);
    // Pointers carry random upper bits and aim above the register banks
    for (int i = 0; i < 2; i++) begin
      gold[i] = {2'($urandom), 1'b1, 5'($urandom)};
      gold[24 + i] = {2'($urandom), 1'b1, 5'($urandom)};
    end
    for (int i = 0; i < 64; i++) mem[i] = gold[i];
    {s_acc, s_tv, s_c, s_pb, s_rb, s_tr, s_cr, s_ov} = '0;
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    wait_note(1);
    // This order leaves both bank 0 pointers holding pointer values
    xch_reg(3'h1);
    xch_reg(3'h0);
    for (int i = 1; i < 8; i++) xch_reg(3'(i));
    for (int i = 0; i < 4; i++) op1(rot_ops[i]);
    repeat (10) op1(rot_ops[$urandom_range(3)]);
    op1(OP_NIBBLE_SWAP);
    op1(8'h00);
    op1(OP_CHOOSE_PROGRAM_BANK_HIGH);
    op1(OP_CHOOSE_PROGRAM_BANK_LOW);
    op1(OP_CHOOSE_REGISTER_BANK_HIGH);
    xch_reg(3'h3);
    xch_ind(OP_ACC_INDIRECT_EXCHANGE);
    xch_ind(OP_ACC_LOW_NIBBLE_EXCHANGE | 8'h01);
    // Interrupt entry with bank 1, bank 0 inside service, restore on exit
    @(posedge sys_clk_i) irq_taken_i <= 1'b1;
    @(posedge sys_clk_i) irq_taken_i <= 1'b0;
    op1(OP_CHOOSE_REGISTER_BANK_LOW);
    @(posedge sys_clk_i) isr_exit_restore_i <= 1'b1;
    @(posedge sys_clk_i) isr_exit_restore_i <= 1'b0;
    s_rb = 1'b1;
    wait_note(0);
    // Entry then exit in the next cycle; the restore beats a bank select
    @(posedge sys_clk_i) irq_taken_i <= 1'b1;
    @(posedge sys_clk_i) begin
      irq_taken_i        <= 1'b0;
      isr_exit_restore_i <= 1'b1;
      op_valid_i         <= 1'b1;
      opcode_i           <= OP_CHOOSE_REGISTER_BANK_LOW;
    end
    @(posedge sys_clk_i) begin
      isr_exit_restore_i <= 1'b0;
      op_valid_i         <= 1'b0;
    end
    wait_note(0);
    op1(OP_CHOOSE_REGISTER_BANK_LOW);
    xch_ind(OP_ACC_INDIRECT_EXCHANGE | 8'h01);
    xch_ind(OP_ACC_LOW_NIBBLE_EXCHANGE);
    xch_reg(3'h7);
    // Interval timer from FE, restart in mid-period must delay the tick
    @(posedge sys_clk_i) begin
      timer_load_i      <= 1'b1;
      timer_load_data_i <= 8'hfe;
    end
    @(posedge sys_clk_i) timer_load_i <= 1'b0;
    s_tv = 8'hfe;
    wait_note(0);
    op1(OP_BEGIN_INTERVAL_TIMING);
    repeat (20) @(posedge sys_clk_i);
    op1(OP_BEGIN_INTERVAL_TIMING);
    wait_note(25);
    s_tv = 8'hff;
    wait_note(10);
    s_tv = 8'h00;
    s_ov = 1'b1;
    wait_note(28);
    s_ov = 1'b0;
    op1(OP_HALT_TIMER_COUNTER);
    wait_note(40);
    // Event counting on falling edges of the pin
    op1(OP_BEGIN_EVENT_COUNTING);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) op1(OP_HALT_TIMER_COUNTER);
      @(posedge sys_clk_i) event_count_input_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      event_count_input_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      if (k < 3) s_tv = s_tv + 8'h01;
    end
    wait_note(8);
    summarize();
  end
endmodule
`default_nettype wire
